// [rtl/dmc_params.svh]
// constants of the DDR memory controller with ECC
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH
`define DMC_OFF_BASE 8'h00
`define DMC_OFF_RANK0 8'h04
`define DMC_OFF_RANK1 8'h08
`define DMC_OFF_CTRL 8'h0C
`define DMC_OFF_STATUS 8'h10
`define DMC_OFF_ERRADDR 8'h14
`define DMC_CTRL_RST 12'hACA
`define DMC_CTRL_ECC 0
`define DMC_CTRL_W32 1
`define DMC_CTRL_LEAF_LSB 3
`define DMC_CTRL_COL_LSB 8
`define DMC_ST_MBE 0
`define DMC_ST_SBE 1
`define DMC_REGION_LSB 24
`define DMC_DISCONNECT_LSB 7
`define DMC_CLK_MHZ 20
`define DMC_T_RCD_NS 20
`define DMC_T_RP_NS 20
`define DMC_T_WR_NS 15
`define DMC_RCD_CYC ((`DMC_T_RCD_NS * `DMC_CLK_MHZ + 999) / 1000)
`define DMC_RP_CYC ((`DMC_T_RP_NS * `DMC_CLK_MHZ + 999) / 1000)
`define DMC_WR_CYC ((`DMC_T_WR_NS * `DMC_CLK_MHZ + 999) / 1000)
`define DMC_CL 3
`define DMC_WL 1
`define DMC_BL 4
`define DMC_CMD_ACT 3'h3
`define DMC_CMD_RD 3'h5
`define DMC_CMD_WR 3'h4
`define DMC_CMD_PRE 3'h2
`define DMC_CMD_NOP 3'h7
`define DMC_RESP_OKAY 2'h0
`define DMC_RESP_SLVERR 2'h2
`endif

// [rtl/dmc_pkg.sv]
// types shared by the DDR memory controller files
package dmc_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } dmc_req_type;
  typedef struct packed {
    logic ready;
    logic done;
    logic err;
    logic disconnect;
    logic [31:0] rdata;
  } dmc_rsp_type;
  typedef struct packed {
    logic [1:0] cs_n;
    logic [2:0] cmd;
    logic [1:0] ba;
    logic [14:0] a;
  } dmc_cmd_type;
  typedef enum logic [3:0] {
    S_IDLE, S_ACT, S_RCD, S_RD, S_RDW, S_CHK, S_WR, S_WRW, S_PRE, S_RP
  } dmc_state_type;
endpackage

// [rtl/dmc_ecc.sv]
// SEC-DED check code generator and corrector
`timescale 1ns/1ps
`default_nettype none
module dmc_ecc (
  input wire logic [31:0] data,
  input wire logic [7:0] check_in,
  output logic [7:0] check_out,
  output logic [31:0] fixed,
  output logic single_err,
  output logic multi_err
);
  // column codes: distinct 7-bit values that are not powers of two
  function automatic logic [6:0] col_of(input int idx);
    logic [6:0] r;
    int n;
    r = 7'h00;
    n = 0;
    for (int v = 3; v < 128; v++) begin
      if ((v & (v - 1)) != 0) begin
        if (n == idx) r = 7'(v);
        n++;
      end
    end
    return r;
  endfunction

  logic [63:0] wide;
  logic [6:0] syn;
  logic odd;

  always_comb begin
    wide = {32'h0000_0000, data};
    check_out[6:0] = 7'h00;
    for (int i = 0; i < 64; i++) begin
      if (wide[i]) check_out[6:0] = check_out[6:0] ^ col_of(i);
    end
    check_out[7] = ^{wide, check_out[6:0]};
    syn = check_out[6:0] ^ check_in[6:0];
    odd = ^{data, check_in};
    single_err = odd;
    multi_err = !odd && (syn != 7'h00);
    fixed = data;
    for (int i = 0; i < 32; i++) begin
      if (odd && col_of(i) == syn) fixed[i] = !data[i];
    end
  end
endmodule
`default_nettype wire

// [rtl/dmc_top.sv]
// multi-port DDR memory controller with ECC and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_top
  import dmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire dmc_req_type proc_req,
  output dmc_rsp_type proc_rsp,
  input wire dmc_req_type bus0_req,
  output dmc_rsp_type bus0_rsp,
  input wire dmc_req_type bus1_req,
  output dmc_rsp_type bus1_rsp,
  output dmc_cmd_type mem_cmd,
  output logic [31:0] dq_out,
  input wire logic [31:0] dq_in,
  output logic dq_oe_n,
  output logic [4:0] dm,
  output logic [7:0] check_bits_out,
  input wire logic [7:0] check_bits_in,
  output logic check_bits_oe_n
);
  localparam logic [3:0] RCD = 4'(`DMC_RCD_CYC);
  localparam logic [3:0] RP = 4'(`DMC_RP_CYC);
  localparam logic [3:0] WRC = 4'(`DMC_WR_CYC);
  localparam logic [3:0] CL = 4'(`DMC_CL);
  localparam logic [3:0] WL = 4'(`DMC_WL);
  localparam logic [3:0] BL = 4'(`DMC_BL);
  localparam logic [3:0] RD_END = CL + BL - 4'h1;
  localparam logic [3:0] WR_END = WL + BL - 4'h1 + WRC;

  // ==========================================================
  // register file over AXI4-Lite
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] base;
  logic [7:0] size0;
  logic [7:0] size1;
  logic [11:0] ctrl;
  logic [1:0] status;
  logic [31:0] err_addr;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic set_mbe;
  logic set_sbe;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wa = {aw_addr[7:2], 2'h0};
  assign ra = {s_axi_araddr[7:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DMC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wa <= `DMC_OFF_ERRADDR) begin
        s_axi_bresp <= `DMC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `DMC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base <= 8'h00;
      size0 <= 8'h00;
      size1 <= 8'h00;
      ctrl <= `DMC_CTRL_RST;
    end else if (do_write && w_strb[3] && wa == `DMC_OFF_BASE) begin
      base <= w_data[31:24];
    end else if (do_write && w_strb[3] && wa == `DMC_OFF_RANK0) begin
      size0 <= w_data[31:24];
    end else if (do_write && w_strb[3] && wa == `DMC_OFF_RANK1) begin
      size1 <= w_data[31:24];
    end else if (do_write && wa == `DMC_OFF_CTRL) begin
      if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
      if (w_strb[1]) ctrl[11:8] <= w_data[11:8];
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    if (ra == `DMC_OFF_BASE) begin
      rd_mux = {base, 24'h00_0000};
    end else if (ra == `DMC_OFF_RANK0) begin
      rd_mux = {size0, 24'h00_0000};
    end else if (ra == `DMC_OFF_RANK1) begin
      rd_mux = {size1, 24'h00_0000};
    end else if (ra == `DMC_OFF_CTRL) begin
      rd_mux = {20'h0_0000, ctrl};
    end else if (ra == `DMC_OFF_STATUS) begin
      rd_mux = {30'h0000_0000, status};
    end else if (ra == `DMC_OFF_ERRADDR) begin
      rd_mux = err_addr;
    end else begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `DMC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `DMC_RESP_OKAY : `DMC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // arbitration and address decode
  dmc_req_type reqs [3];
  dmc_req_type rq;
  dmc_state_type state;
  logic [3:0] cnt;
  logic rr;
  logic any;
  logic [1:0] sel;
  logic take;
  logic ecc_on;
  logic w32;
  logic [31:0] off;
  logic [31:0] roff;
  logic [31:0] word;
  logic [31:0] col32;
  logic [31:0] row32;
  logic [31:0] ba32;
  logic [8:0] top;
  logic hit;
  logic hit1;

  assign reqs[0] = proc_req;
  assign reqs[1] = bus0_req;
  assign reqs[2] = bus1_req;
  assign w32 = ctrl[`DMC_CTRL_W32];
  assign ecc_on = ctrl[`DMC_CTRL_ECC] && w32;

  always_comb begin
    any = 1'b1;
    if (reqs[0].valid) begin
      sel = 2'h0;
    end else if (reqs[1].valid && (!rr || !reqs[2].valid)) begin
      sel = 2'h1;
    end else if (reqs[2].valid) begin
      sel = 2'h2;
    end else begin
      sel = 2'h0;
      any = 1'b0;
    end
  end

  always_comb begin
    rq = reqs[sel];
    take = any && state == S_IDLE;
    off = rq.addr - {base, 24'h00_0000};
    top = {1'b0, size0} + {1'b0, size1};
    hit = rq.addr[31:`DMC_REGION_LSB] >= base && {1'b0, off[31:`DMC_REGION_LSB]} < top;
    hit1 = off[31:`DMC_REGION_LSB] >= size0;
    roff = hit1 ? off - {size0, 24'h00_0000} : off;
    word = w32 ? roff >> 2 : roff >> 1;
    col32 = word & ~(32'hFFFF_FFFF << ctrl[11:`DMC_CTRL_COL_LSB]);
    row32 = word >> ctrl[11:`DMC_CTRL_COL_LSB];
    ba32 = roff >> ctrl[7:`DMC_CTRL_LEAF_LSB];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rr <= 1'b0;
    end else if (take && sel == 2'h1) begin
      rr <= 1'b1;
    end else if (take && sel == 2'h2) begin
      rr <= 1'b0;
    end
  end

  // ==========================================================
  // access sequencer
  logic [1:0] cur_port;
  logic cur_write;
  logic cur_rmw;
  logic cur_rank;
  logic [3:0] cur_be;
  logic [31:0] cur_addr;
  logic [11:0] cur_col;
  logic [14:0] cur_row;
  logic [1:0] cur_ba;
  logic [31:0] wr_word;
  logic [31:0] beat0;
  logic [15:0] beat1;
  logic [7:0] rd_chk;
  logic [31:0] rd_word;
  logic [7:0] wr_code;
  logic [31:0] fixed;
  logic single;
  logic multi;
  logic [31:0] merged;

  assign rd_word = w32 ? beat0 : {beat1, beat0[15:0]};

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      merged[b*8 +: 8] = cur_be[b] ? wr_word[b*8 +: 8] : fixed[b*8 +: 8];
    end
  end

  dmc_ecc u_ecc_rd (
    .data(rd_word),
    .check_in(rd_chk),
    .check_out(),
    .fixed(fixed),
    .single_err(single),
    .multi_err(multi)
  );

  dmc_ecc u_ecc_wr (
    .data(wr_word),
    .check_in(8'h00),
    .check_out(wr_code),
    .fixed(),
    .single_err(),
    .multi_err()
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= S_IDLE;
      cnt <= 4'h0;
    end else begin
      case (state)
        S_IDLE: begin
          if (take && hit) state <= S_ACT;
        end
        S_ACT: begin
          state <= S_RCD;
          cnt <= RCD - 4'h1;
        end
        S_RCD: begin
          if (cnt == 4'h0) begin
            state <= (cur_write && !cur_rmw) ? S_WR : S_RD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        S_RD: begin
          state <= S_RDW;
          cnt <= 4'h0;
        end
        S_RDW: begin
          if (cnt == RD_END) state <= S_CHK;
          else cnt <= cnt + 4'h1;
        end
        S_CHK: begin
          // a double error skips the write of the merged word so bad data never gets a fresh code
          state <= (cur_rmw && !multi) ? S_WR : S_PRE;
        end
        S_WR: begin
          state <= S_WRW;
          cnt <= 4'h0;
        end
        S_WRW: begin
          if (cnt == WR_END) state <= S_PRE;
          else cnt <= cnt + 4'h1;
        end
        S_PRE: begin
          state <= S_RP;
          cnt <= RP - 4'h1;
        end
        S_RP: begin
          if (cnt == 4'h0) state <= S_IDLE;
          else cnt <= cnt - 4'h1;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_port <= 2'h0;
      cur_write <= 1'b0;
      cur_rmw <= 1'b0;
      cur_rank <= 1'b0;
      cur_be <= 4'h0;
      cur_addr <= 32'h0000_0000;
      cur_col <= 12'h000;
      cur_row <= 15'h0000;
      cur_ba <= 2'h0;
      wr_word <= 32'h0000_0000;
    end else if (take) begin
      cur_port <= sel;
      cur_write <= rq.write;
      cur_rmw <= rq.write && ecc_on && rq.be != 4'hF;
      cur_rank <= hit1;
      cur_be <= rq.be;
      cur_addr <= rq.addr;
      cur_col <= col32[11:0];
      cur_row <= row32[14:0];
      cur_ba <= ba32[1:0];
      wr_word <= rq.wdata;
    end else if (state == S_CHK && cur_rmw) begin
      wr_word <= merged;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      beat0 <= 32'h0000_0000;
      beat1 <= 16'h0000;
      rd_chk <= 8'h00;
    end else if (state == S_RDW && cnt == CL) begin
      beat0 <= dq_in;
      rd_chk <= ecc_on ? check_bits_in : 8'h00;
    end else if (state == S_RDW && cnt == CL + 4'h1) begin
      beat1 <= dq_in[15:0];
    end
  end

  // ==========================================================
  // port answers
  logic [2:0] done_q;
  logic [2:0] disc_q;
  logic err_q;
  logic [31:0] rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 3'h0;
      disc_q <= 3'h0;
      err_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      done_q <= 3'h0;
      disc_q <= 3'h0;
      if (take && !hit) begin
        done_q[sel] <= 1'b1;
        err_q <= 1'b1;
      end
      // bus port bursts past the 128-byte mark restart so no page is ever crossed; the processor port is never disconnected
      if (take && sel != 2'h0 && rq.addr[`DMC_DISCONNECT_LSB-1:2] == 5'h1F) disc_q[sel] <= 1'b1;
      if (state == S_CHK && !cur_write) begin
        done_q[cur_port] <= 1'b1;
        err_q <= ecc_on && multi;
        rdata_q <= ecc_on ? fixed : rd_word;
      end
      if (state == S_CHK && cur_rmw && multi) begin
        done_q[cur_port] <= 1'b1;
        err_q <= 1'b1;
      end
      if (state == S_WRW && cnt == WR_END) begin
        done_q[cur_port] <= 1'b1;
        err_q <= 1'b0;
      end
    end
  end

  always_comb begin
    proc_rsp = '{ready: take && sel == 2'h0, done: done_q[0], err: err_q, disconnect: disc_q[0], rdata: rdata_q};
    bus0_rsp = '{ready: take && sel == 2'h1, done: done_q[1], err: err_q, disconnect: disc_q[1], rdata: rdata_q};
    bus1_rsp = '{ready: take && sel == 2'h2, done: done_q[2], err: err_q, disconnect: disc_q[2], rdata: rdata_q};
  end

  // ==========================================================
  // error status, write one to clear, set wins
  assign set_mbe = state == S_CHK && ecc_on && multi;
  assign set_sbe = state == S_CHK && ecc_on && single;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= 2'h0;
      err_addr <= 32'h0000_0000;
    end else begin
      if (set_mbe) begin
        status[`DMC_ST_MBE] <= 1'b1;
      end else if (do_write && wa == `DMC_OFF_STATUS && w_strb[0] && w_data[`DMC_ST_MBE]) begin
        status[`DMC_ST_MBE] <= 1'b0;
      end
      if (set_sbe) begin
        status[`DMC_ST_SBE] <= 1'b1;
      end else if (do_write && wa == `DMC_OFF_STATUS && w_strb[0] && w_data[`DMC_ST_SBE]) begin
        status[`DMC_ST_SBE] <= 1'b0;
      end
      if (set_mbe || set_sbe) err_addr <= cur_addr;
    end
  end

  // ==========================================================
  // memory pins, registered
  logic [3:0] beat;
  logic wbeat;

  assign beat = cnt - (WL - 4'h1);
  assign wbeat = state == S_WRW && cnt >= WL - 4'h1 && cnt <= WL + BL - 4'h2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_cmd <= '{cs_n: 2'h3, cmd: `DMC_CMD_NOP, ba: 2'h0, a: 15'h0000};
      dq_out <= 32'h0000_0000;
      dq_oe_n <= 1'b1;
      dm <= 5'h1F;
      check_bits_out <= 8'h00;
      check_bits_oe_n <= 1'b1;
    end else begin
      mem_cmd <= '{cs_n: 2'h3, cmd: `DMC_CMD_NOP, ba: cur_ba, a: 15'h0000};
      dq_oe_n <= 1'b1;
      check_bits_oe_n <= 1'b1;
      dm <= 5'h1F;
      case (state)
        S_ACT: begin
          mem_cmd.cs_n[cur_rank] <= 1'b0;
          mem_cmd.cmd <= `DMC_CMD_ACT;
          mem_cmd.a <= cur_row;
        end
        S_RD, S_WR: begin
          mem_cmd.cs_n[cur_rank] <= 1'b0;
          mem_cmd.cmd <= state == S_RD ? `DMC_CMD_RD : `DMC_CMD_WR;
          mem_cmd.a <= {3'h0, cur_col[10], 1'b0, cur_col[9:0]};
        end
        S_PRE: begin
          mem_cmd.cs_n[cur_rank] <= 1'b0;
          mem_cmd.cmd <= `DMC_CMD_PRE;
          mem_cmd.a <= 15'h0400;
        end
        default: begin
        end
      endcase
      if (wbeat) begin
        // all four beats are driven; unused beats are masked, checks too
        dq_oe_n <= 1'b0;
        check_bits_oe_n <= !ecc_on;
        check_bits_out <= wr_code;
        if (w32) begin
          dq_out <= wr_word;
          if (beat == 4'h0) dm <= {!ecc_on, cur_rmw ? 4'h0 : ~cur_be};
        end else begin
          dq_out <= {16'h0000, beat == 4'h0 ? wr_word[15:0] : wr_word[31:16]};
          if (beat == 4'h0) dm <= {3'h7, ~cur_be[1:0]};
          if (beat == 4'h1) dm <= {3'h7, ~cur_be[3:2]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/dmc_top_chk.sv]
// port assertions for the DDR memory controller
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_top_chk
  import dmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dmc_req_type proc_req,
  input wire dmc_rsp_type proc_rsp,
  input wire dmc_req_type bus0_req,
  input wire dmc_rsp_type bus0_rsp,
  input wire dmc_rsp_type bus1_rsp,
  input wire dmc_cmd_type mem_cmd,
  input wire logic dq_oe_n,
  input wire logic check_bits_oe_n
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic wr_cmd;
  assign wr_cmd = mem_cmd.cs_n != 2'h3 && mem_cmd.cmd == `DMC_CMD_WR;
  // =====================================
  // sequences
  sequence s_rd_acc;
    proc_req.valid && !proc_req.write && proc_rsp.ready;
  endsequence
  sequence s_wr_issue;
    wr_cmd;
  endsequence
  // =====================================
  // properties
  AST_ONE_RANK: assert property (mem_cmd.cs_n != 2'h0)
    else $error("both chip enables low");
  AST_CB_WITH_DATA: assert property (!check_bits_oe_n |-> !dq_oe_n)
    else $error("check bits driven without data");
  AST_WR_DATA: assert property (s_wr_issue |-> ##[0:2] !dq_oe_n)
    else $error("write command without data");
  AST_BURST_FOUR: assert property (s_wr_issue |=> !wr_cmd [*3])
    else $error("write burst cut short");
  AST_PROC_FIRST: assert property ((bus0_rsp.ready || bus1_rsp.ready) |-> !proc_req.valid)
    else $error("bus port granted over processor");
  AST_ONE_GRANT: assert property ($onehot0({proc_rsp.ready, bus0_rsp.ready, bus1_rsp.ready}))
    else $error("two ports granted");
  AST_DISCONNECT: assert property ((bus0_req.valid && bus0_rsp.ready && bus0_req.addr[6:2] == 5'h1F)
    |=> bus0_rsp.disconnect)
    else $error("no disconnect at boundary");
  AST_PROC_NO_DISC: assert property (!proc_rsp.disconnect)
    else $error("processor port disconnected");
  AST_READ_NO_WRITE: assert property (s_rd_acc |=> (!wr_cmd throughout (##[0:40] proc_rsp.done)))
    else $error("read wrote memory");
endmodule
bind dmc_top dmc_top_chk u_chk (.aclk, .aresetn, .proc_req, .proc_rsp, .bus0_req, .bus0_rsp, .bus1_rsp,
  .mem_cmd, .dq_oe_n, .check_bits_oe_n);
`default_nettype wire

// [testbench/dmc_mem_model.sv]
// behavioural model of the discrete DDR chips
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module dmc_mem_model
  import dmc_pkg::*;
(
  input wire logic aclk,
  input wire dmc_cmd_type mem_cmd,
  input wire logic [31:0] dq_out,
  input wire logic dq_oe_n,
  input wire logic [4:0] dm,
  input wire logic [7:0] check_bits_out,
  input wire logic check_bits_oe_n,
  input wire logic [31:0] flip,
  output logic [31:0] dq_in,
  output logic [7:0] check_bits_in,
  output int rd_cnt,
  output logic [1:0] last_cs
);
  logic [39:0] mem [logic [33:0]];
  logic [14:0] row [4];
  logic [33:0] rk;
  logic [33:0] wk;
  logic [39:0] w;
  logic [33:0] k;
  int rd_t = 99;
  int wr_t = 99;
  initial rd_cnt = 0;
  initial dq_in = 32'h5A5A_5A5A;
  initial check_bits_in = 8'hA5;
  // =====================================
  // commands and data beats
  always @(posedge aclk) begin
    rd_t <= rd_t + 1;
    wr_t <= wr_t + 1;
    if (mem_cmd.cs_n != 2'h3 && mem_cmd.cmd == `DMC_CMD_ACT)
      row[mem_cmd.ba] <= mem_cmd.a;
    if (mem_cmd.cs_n != 2'h3 && mem_cmd.cmd == `DMC_CMD_RD) begin
      rk <= {mem_cmd.cs_n, mem_cmd.ba, row[mem_cmd.ba], mem_cmd.a};
      rd_t <= 0;
      rd_cnt <= rd_cnt + 1;
    end
    if (mem_cmd.cs_n != 2'h3 && mem_cmd.cmd == `DMC_CMD_WR) begin
      wk = {mem_cmd.cs_n, mem_cmd.ba, row[mem_cmd.ba], mem_cmd.a};
      wr_t <= 0;
      last_cs <= mem_cmd.cs_n;
    end
    // beats follow the read latency; each beat is its own column
    k = rk + 34'(rd_t + 2 - `DMC_CL);
    if (rd_t >= `DMC_CL - 2 && rd_t < `DMC_CL + 2) begin
      w = mem.exists(k) ? mem[k] : 40'h0;
      dq_in <= w[31:0] ^ flip;
      check_bits_in <= w[39:32];
    end else begin
      // released lines toggle so a stale value never looks valid
      dq_in <= ~dq_in;
      check_bits_in <= ~check_bits_in;
    end
    if (wr_t < 4 && !dq_oe_n) begin
      k = wk + 34'(wr_t);
      w = mem.exists(k) ? mem[k] : 40'h0;
      for (int b = 0; b < 4; b++)
        if (!dm[b]) w[8*b+:8] = dq_out[8*b+:8];
      if (!dm[4] && !check_bits_oe_n) w[39:32] = check_bits_out;
      mem[k] = w;
    end
  end
endmodule
`default_nettype wire

// [testbench/test_ddr_memory_controller_ecc.sv]
// self-checking bench for the DDR memory controller with ECC
`timescale 1ns/1ps
`default_nettype none
`include "dmc_params.svh"
module test_ddr_memory_controller_ecc;
  import dmc_pkg::*;
  localparam logic [31:0] A0 = 32'h0100_0010;
  localparam logic [31:0] A1 = 32'h0200_0010;
  localparam logic [31:0] D0 = 32'hC3A5_1E69;
  localparam logic [31:0] D1 = 32'h0F1E_2D3C;
  logic aclk = '0;
  logic aresetn = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, flip = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dq_oe_n, check_bits_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp, last_cs;
  logic [31:0] s_axi_rdata, dq_out, dq_in;
  logic [7:0] check_bits_out, check_bits_in;
  logic [4:0] dm;
  dmc_req_type rq [3] = '{default: '0};
  dmc_rsp_type rs [3];
  dmc_cmd_type mem_cmd;
  int rd_cnt;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  dmc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .proc_req(rq[0]),
    .proc_rsp(rs[0]), .bus0_req(rq[1]), .bus0_rsp(rs[1]), .bus1_req(rq[2]), .bus1_rsp(rs[2]), .mem_cmd,
    .dq_out, .dq_in, .dq_oe_n, .dm, .check_bits_out, .check_bits_in, .check_bits_oe_n);
  dmc_mem_model u_mem (.aclk, .mem_cmd, .dq_out, .dq_oe_n, .dm, .check_bits_out, .check_bits_in,
    .check_bits_oe_n, .flip, .dq_in, .rd_cnt, .last_cs);
  always #25 aclk = ~aclk;
  // =====================================
  // shared tasks
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axw(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= '0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= ad;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= '0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= '0;
    @(posedge aclk);
  endtask
  task automatic acc(input int p, input logic wr, input logic [31:0] ad, input logic [31:0] d,
    input logic [3:0] be, output logic [31:0] q, output logic e);
    rq[p] <= '{1'b1, wr, ad, d, be};
    do @(posedge aclk); while (!rs[p].ready);
    rq[p].valid <= '0;
    do @(posedge aclk); while (!rs[p].done);
    q = rs[p].rdata;
    e = rs[p].err;
  endtask
  // =====================================
  // scenarios
  task automatic t_reg;
    logic [31:0] d;
    logic [1:0] r;
    axr(8'h0C, d, r);
    chk("ctrl reset", 32'h0000_0ACA, d);
    axr(8'h18, d, r);
    chk("unmapped rresp", 32'h2, {30'h0, r});
    axw(8'h1C, 32'h0, r);
    chk("unmapped bresp", 32'h2, {30'h0, r});
    axw(8'h00, 32'h0100_0000, r);
    axw(8'h04, 32'h0100_0000, r);
    axw(8'h08, 32'h0100_0000, r);
    axw(8'h0C, 32'h0000_0ACB, r);
    axr(8'h00, d, r);
    chk("base", 32'h0100_0000, d);
  endtask
  task automatic t_rank;
    logic [31:0] q;
    logic e;
    acc(0, 1, A0, D0, 4'hF, q, e);
    chk("rank0 select", 32'h2, {30'h0, last_cs});
    acc(2, 1, A1, D1, 4'hF, q, e);
    chk("rank1 select", 32'h1, {30'h0, last_cs});
    acc(1, 0, A1, '0, 4'h0, q, e);
    chk("rank1 data", D1, q);
    acc(0, 0, 32'h0300_0000, '0, 4'h0, q, e);
    chk("above ranks err", 32'h1, {31'h0, e});
    acc(0, 0, 32'h0000_0100, '0, 4'h0, q, e);
    chk("below base err", 32'h1, {31'h0, e});
  endtask
  task automatic t_ecc;
    logic [31:0] q;
    logic [31:0] d;
    logic [1:0] r;
    logic e;
    flip <= 32'h0000_0100;
    acc(0, 0, A0, '0, 4'h0, q, e);
    chk("corrected", D0, q);
    axr(8'h10, d, r);
    chk("single flag", 32'h2, d);
    flip <= 32'h0000_0300;
    acc(0, 0, A0, '0, 4'h0, q, e);
    chk("double err", 32'h1, {31'h0, e});
    axr(8'h10, d, r);
    chk("double flag", 32'h3, d);
    axr(8'h14, d, r);
    chk("err addr", A0, d);
    axw(8'h10, 32'h3, r);
    axr(8'h10, d, r);
    chk("flags cleared", 32'h0, d);
    flip <= '0;
    acc(0, 0, A0, '0, 4'h0, q, e);
    chk("no scrub", D0, q);
  endtask
  task automatic t_rmw;
    logic [31:0] q;
    logic [31:0] n;
    logic e;
    n = rd_cnt;
    acc(1, 1, A0, 32'h0000_7700, 4'h2, q, e);
    chk("rmw read", n + 1, rd_cnt);
    acc(0, 0, A0, '0, 4'h0, q, e);
    chk("rmw merge", {D0[31:16], 8'h77, D0[7:0]}, q);
    chk("rmw code", 32'h0, {31'h0, e});
  endtask
  task automatic t_noecc;
    logic [31:0] q;
    logic [31:0] n;
    logic [1:0] r;
    logic e;
    axw(8'h0C, 32'h0000_0ACA, r);
    n = rd_cnt;
    acc(0, 1, A1, 32'h0000_0055, 4'h1, q, e);
    chk("direct byte write", n, rd_cnt);
    flip <= 32'h0000_0001;
    acc(0, 0, A1, '0, 4'h0, q, e);
    chk("raw data", {D1[31:8], 8'h54}, q);
    flip <= '0;
    axw(8'h0C, 32'h0000_0AC9, r);
    acc(0, 1, A0, D1, 4'hF, q, e);
    acc(0, 0, A0, '0, 4'h0, q, e);
    chk("16-bit word", D1, q);
    chk("16-bit no check", 32'h0, {31'h0, e});
  endtask
  task automatic t_arb;
    logic [31:0] q;
    logic e;
    time t [3];
    fork
      begin
        acc(0, 0, A0, '0, 4'h0, q, e);
        t[0] = $time;
      end
      begin
        acc(1, 0, 32'h0100_007C, '0, 4'h0, q, e);
        t[1] = $time;
      end
      begin
        acc(2, 0, A1, '0, 4'h0, q, e);
        t[2] = $time;
      end
    join
    chk("processor first", 32'h1, {31'h0, t[0] < t[1] && t[0] < t[2]});
  endtask
  // =====================================
  // sequence and watchdog
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      test_done;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    t_reg;
    t_rank;
    t_ecc;
    t_rmw;
    t_noecc;
    t_arb;
    test_done;
  end
endmodule
`default_nettype wire
